// [shared/dhfc_map.svh]
`ifndef DHFC_MAP_SVH
`define DHFC_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define DHFC_ADDR_FREEZE_LOW   32'h4001_5808
`define DHFC_ADDR_FREEZE_HIGH  32'h4001_580C
`define DHFC_ADDR_STATUS       32'h4001_5810

// ****************************************************************
// Reset values and writable bit masks
// ****************************************************************
`define DHFC_FREEZE_RST        32'h0000_0000
`define DHFC_LOW_MASK          32'h0020_1D32
`define DHFC_HIGH_MASK         32'h0007_0800
`define DHFC_BUS_FULL_SEL      4'hF

// ****************************************************************
// Low freeze register fields
// ****************************************************************
`define DHFC_BIT_TIMER3        1
`define DHFC_BIT_TIMER6        4
`define DHFC_BIT_TIMER7        5
`define DHFC_BIT_TIMER14       8
`define DHFC_BIT_CALENDAR      10
`define DHFC_BIT_WWDG          11
`define DHFC_BIT_IWDG          12
`define DHFC_BIT_TWOWIRE       21

// ****************************************************************
// High freeze register fields
// ****************************************************************
`define DHFC_BIT_TIMER1        11
`define DHFC_BIT_TIMER15       16
`define DHFC_BIT_TIMER16       17
`define DHFC_BIT_TIMER17       18

// ****************************************************************
// Status register fields
// ****************************************************************
`define DHFC_ST_HALTED         0
`define DHFC_ST_SYSRST         1
`define DHFC_ST_CNT_LSB        16
`define DHFC_ST_CNT_W          16

`endif

// [shared/dhfc_pkg.sv]
package dhfc_pkg;

    // One-hot states of the bus slave
    typedef enum logic [2:0]
    {
        DHFC_IDLE = 3'h1,
        DHFC_ACK  = 3'h2,
        DHFC_ERR  = 3'h4
    } dhfc_bus_state_type;

endpackage

// [rtl/dhfc_sync3.sv]
`timescale 1ns/100ps

module dhfc_sync3
(
    // Clock and power-on reset
    input  wire logic clk_i,
    input  wire logic por_i,
    // Foreign level in, settled level out
    input  wire logic async_i,
    output logic      level_o
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ************************************************************
    // Three stages; a change counts once stages two and three agree
    // ************************************************************
    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
        begin
            stage1  <= 1'h0;
            stage2  <= 1'h0;
            stage3  <= 1'h0;
            level_o <= 1'h0;
        end
        else
        begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                level_o <= stage3;
        end
    end

endmodule // dhfc_sync3

// [rtl/dhfc_freeze_reg.sv]
`timescale 1ns/100ps
`include "dhfc_map.svh"

module dhfc_freeze_reg
#(
    parameter logic [31:0] WRITE_MASK = 32'h0000_0000
)
(
    // Clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        por_i,
    // Write port
    input  wire logic        wr_i,
    input  wire logic [31:0] wdata_i,
    // Stored value
    output logic      [31:0] value_o
);

    // ************************************************************
    // Storage
    // ************************************************************
    // System reset is deliberately absent so a debugger setup
    // survives it and writes land while the system is in reset.
    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
            value_o <= `DHFC_FREEZE_RST;
        else if (wr_i)
            value_o <= wdata_i & WRITE_MASK;
    end

endmodule // dhfc_freeze_reg

// [rtl/dhfc_halt_freeze.sv]
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "dhfc_map.svh"

// Behaviour
// - Only power-on reset clears the freeze registers, asynchronously.
// - After power-on both freeze registers read zero; nothing freezes.
// - Writes are accepted while the system is held in reset.
// - Low bit 1 freezes timer 3 while the core is halted.
// - Low bits 4 and 5 freeze timers 6 and 7 during halt.
// - Low bit 8 freezes timer 14 during halt.
// - Low bit 10 freezes the calendar counter during halt.
// - Low bit 11 freezes the window watchdog during halt.
// - Low bit 12 freezes the independent watchdog during halt.
// - Low bit 21 freezes the two-wire bus timeout during halt.
// - High register sits one word above; bit 11 freezes timer 1.
// - High bits 16 and 17 freeze timers 15 and 16 during halt.
// - High bit 18 freezes timer 17 during halt.
module dhfc_halt_freeze
    import dhfc_pkg::*;
(
    // Clock and resets
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Core halt indication from the debug domain
    input  wire logic        core_halted_i,
    // Freeze requests to the peripherals
    output logic             timer1_halt_freeze_o,
    output logic             timer3_halt_freeze_o,
    output logic             timer6_halt_freeze_o,
    output logic             timer7_halt_freeze_o,
    output logic             timer14_halt_freeze_o,
    output logic             timer15_halt_freeze_o,
    output logic             timer16_halt_freeze_o,
    output logic             timer17_halt_freeze_o,
    output logic             calendar_halt_freeze_o,
    output logic             window_watchdog_halt_freeze_o,
    output logic             independent_watchdog_halt_freeze_o,
    output logic             twowire_timeout_halt_freeze_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    dhfc_bus_state_type state;
    dhfc_bus_state_type next_state;

    logic [31:0] freeze_low;
    logic [31:0] freeze_high;
    logic        core_halted;
    logic        halted_prev;
    logic [15:0] halt_entries;
    logic [31:0] status_word;
    logic [31:0] next_dat;
    logic [11:0] freeze_vec;
    logic [11:0] next_freeze_vec;

    wire request;
    wire full_word;
    wire hit_low;
    wire hit_high;
    wire hit_status;
    wire hit_any;
    wire access_ok;
    wire in_ack;
    wire write_low;
    wire write_high;
    wire halt_rise;

    // ************************************************************
    // Core halt crossing
    // ************************************************************
    dhfc_sync3 u_halt_sync
    (
        .clk_i   (clk_i),
        .por_i   (por_i),
        .async_i (core_halted_i),
        .level_o (core_halted)
    );

    // ************************************************************
    // Address decode
    // ************************************************************
    assign request    = wb_cyc_i & wb_stb_i;
    assign full_word  = (wb_sel_i == `DHFC_BUS_FULL_SEL);
    assign hit_low    = (wb_adr_i == `DHFC_ADDR_FREEZE_LOW);
    assign hit_high   = (wb_adr_i == `DHFC_ADDR_FREEZE_HIGH);
    assign hit_status = (wb_adr_i == `DHFC_ADDR_STATUS);
    assign hit_any    = hit_low | hit_high | hit_status;
    assign access_ok  = hit_any & full_word;

    // Write happens at the edge where the master sees ack.
    // Nothing here looks at rst_i, so the debugger can still
    // program the freeze bits during a system reset.
    assign in_ack     = (state == DHFC_ACK) & request;
    assign write_low  = in_ack & wb_we_i & hit_low;
    assign write_high = in_ack & wb_we_i & hit_high;

    // ************************************************************
    // Freeze registers
    // ************************************************************
    dhfc_freeze_reg
    #(
        .WRITE_MASK (`DHFC_LOW_MASK)
    )
    u_freeze_low
    (
        .clk_i   (clk_i),
        .por_i   (por_i),
        .wr_i    (write_low),
        .wdata_i (wb_dat_i),
        .value_o (freeze_low)
    );

    dhfc_freeze_reg
    #(
        .WRITE_MASK (`DHFC_HIGH_MASK)
    )
    u_freeze_high
    (
        .clk_i   (clk_i),
        .por_i   (por_i),
        .wr_i    (write_high),
        .wdata_i (wb_dat_i),
        .value_o (freeze_high)
    );

    // ************************************************************
    // Halt entry counter
    // ************************************************************
    // Unlike the freeze bits this count is ordinary system state,
    // so a system reset clears it.
    assign halt_rise = core_halted & ~halted_prev;

    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
        begin
            halted_prev  <= 1'h0;
            halt_entries <= 16'h0000;
        end
        else
        begin
            halted_prev <= core_halted;
            if (rst_i)
                halt_entries <= 16'h0000;
            else if (halt_rise)
                halt_entries <= halt_entries + 16'h0001;
        end
    end

    // ************************************************************
    // Status word
    // ************************************************************
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[`DHFC_ST_HALTED] = core_halted;
        status_word[`DHFC_ST_SYSRST] = rst_i;
        status_word[`DHFC_ST_CNT_LSB +: `DHFC_ST_CNT_W] = halt_entries;
    end

    // ************************************************************
    // Read data selection
    // ************************************************************
    always_comb
    begin
        if (!access_ok)
            next_dat = 32'h0000_0000;
        else if (hit_low)
            next_dat = freeze_low;
        else if (hit_high)
            next_dat = freeze_high;
        else
            next_dat = status_word;
    end

    // ************************************************************
    // Bus slave state machine
    // ************************************************************
    // One wait-free answer: the request seen in idle is answered in
    // the next cycle, then the slave returns to idle so ack drops.
    always_comb
    begin
        next_state = state;
        case (state)
            DHFC_IDLE:
            begin
                if (request && access_ok)
                    next_state = DHFC_ACK;
                else if (request)
                    next_state = DHFC_ERR;
            end
            DHFC_ACK:
            begin
                next_state = DHFC_IDLE;
            end
            DHFC_ERR:
            begin
                next_state = DHFC_IDLE;
            end
            default:
            begin
                next_state = DHFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
        begin
            state    <= DHFC_IDLE;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            if (state == DHFC_IDLE)
                wb_dat_o <= next_dat;
        end
    end

    // Answers are qualified by the live request so an abandoned
    // cycle never sees a stray ack.
    assign wb_ack_o = (state == DHFC_ACK) & request;
    assign wb_err_o = (state == DHFC_ERR) & request;

    // ************************************************************
    // Freeze outputs
    // ************************************************************
    always_comb
    begin
        next_freeze_vec[0]  = freeze_high[`DHFC_BIT_TIMER1];
        next_freeze_vec[1]  = freeze_low[`DHFC_BIT_TIMER3];
        next_freeze_vec[2]  = freeze_low[`DHFC_BIT_TIMER6];
        next_freeze_vec[3]  = freeze_low[`DHFC_BIT_TIMER7];
        next_freeze_vec[4]  = freeze_low[`DHFC_BIT_TIMER14];
        next_freeze_vec[5]  = freeze_high[`DHFC_BIT_TIMER15];
        next_freeze_vec[6]  = freeze_high[`DHFC_BIT_TIMER16];
        next_freeze_vec[7]  = freeze_high[`DHFC_BIT_TIMER17];
        next_freeze_vec[8]  = freeze_low[`DHFC_BIT_CALENDAR];
        next_freeze_vec[9]  = freeze_low[`DHFC_BIT_WWDG];
        next_freeze_vec[10] = freeze_low[`DHFC_BIT_IWDG];
        next_freeze_vec[11] = freeze_low[`DHFC_BIT_TWOWIRE];
        if (!core_halted)
            next_freeze_vec = 12'h000;
    end

    // Registered so peripherals see a glitch-free level
    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
            freeze_vec <= 12'h000;
        else
            freeze_vec <= next_freeze_vec;
    end

    assign timer1_halt_freeze_o               = freeze_vec[0];
    assign timer3_halt_freeze_o               = freeze_vec[1];
    assign timer6_halt_freeze_o               = freeze_vec[2];
    assign timer7_halt_freeze_o               = freeze_vec[3];
    assign timer14_halt_freeze_o              = freeze_vec[4];
    assign timer15_halt_freeze_o              = freeze_vec[5];
    assign timer16_halt_freeze_o              = freeze_vec[6];
    assign timer17_halt_freeze_o              = freeze_vec[7];
    assign calendar_halt_freeze_o             = freeze_vec[8];
    assign window_watchdog_halt_freeze_o      = freeze_vec[9];
    assign independent_watchdog_halt_freeze_o = freeze_vec[10];
    assign twowire_timeout_halt_freeze_o      = freeze_vec[11];

endmodule // dhfc_halt_freeze

// [sim/dhfc_halt_freeze_sva.sv]
`timescale 1ns/100ps
`include "dhfc_map.svh"

module dhfc_halt_freeze_sva
(
    // Clock and resets
    input  wire logic        clk_i,
    input  wire logic        por_i,
    input  wire logic        rst_i,
    // Bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o,
    // Halt and one watched freeze line
    input  wire logic        core_halted_i,
    input  wire logic        timer3_halt_freeze_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (por_i);

    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire lo  = wb_adr_i == `DHFC_ADDR_FREEZE_LOW;
    wire hi  = wb_adr_i == `DHFC_ADDR_FREEZE_HIGH;

    a_narrow_err: assert property (
        req && wb_sel_i != 4'hF |=> wb_err_o && !wb_ack_o)
        else $error("narrow access not refused");
    a_word_ack: assert property (
        req && wb_sel_i == 4'hF && (lo || hi) |=> wb_ack_o && !wb_err_o)
        else $error("word access not acknowledged");
    a_rsv_zero: assert property (
        wb_ack_o && !wb_we_i && (lo || hi) |-> (wb_dat_o &
        ~(lo ? `DHFC_LOW_MASK : `DHFC_HIGH_MASK)) == 32'h0)
        else $error("reserved bit read as one");
    a_idle_off: assert property (
        !core_halted_i [*7] |-> !timer3_halt_freeze_o)
        else $error("freeze while not halted");
    a_rise_hist: assert property (
        $rose(timer3_halt_freeze_o) |-> $past(core_halted_i, 5))
        else $error("freeze rose without halt");
    a_drop_bound: assert property (
        $fell(core_halted_i) ##1 !core_halted_i [*6]
        |-> !timer3_halt_freeze_o)
        else $error("freeze held after halt ended");
    a_rise_late: assert property (
        !core_halted_i [*7] ##1 core_halted_i
        |-> !timer3_halt_freeze_o [*4])
        else $error("freeze ahead of synchronised halt");
    a_rst_keep: assert property (
        core_halted_i [*6] ##0 (rst_i && timer3_halt_freeze_o && !wb_cyc_i)
        |=> timer3_halt_freeze_o)
        else $error("system reset cleared freeze");

    cover property (req && wb_sel_i != 4'hF);
    cover property ($rose(timer3_halt_freeze_o));
    cover property (rst_i && wb_ack_o && wb_we_i);
endmodule // dhfc_halt_freeze_sva

bind dhfc_halt_freeze dhfc_halt_freeze_sva chk_u
(
    .clk_i(clk_i), .por_i(por_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .core_halted_i(core_halted_i),
    .timer3_halt_freeze_o(timer3_halt_freeze_o)
);

// [sim/dhfc_counter_model.sv]
`timescale 1ns/100ps

module dhfc_counter_model
(
    // Clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        por_i,
    // Freeze request and count
    input  wire logic        freeze_i,
    output logic      [15:0] count_o
);
    // A frozen count must not move, or a halted debug view drifts
    always_ff @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
            count_o <= 16'h0000;
        else if (!freeze_i)
            count_o <= count_o + 16'h0001;
    end
endmodule // dhfc_counter_model

// [sim/tb.sv]
`timescale 1ns/100ps
`include "dhfc_map.svh"

module tb;
    localparam logic [31:0] AL = `DHFC_ADDR_FREEZE_LOW;
    localparam logic [31:0] AH = `DHFC_ADDR_FREEZE_HIGH;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        por_i = 1'h1;
    logic        cyc   = 1'h0;
    logic        stb   = 1'h0;
    logic        we    = 1'h0;
    logic [31:0] adr   = 32'h0;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0;
    logic        halt  = 1'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        err;
    logic [11:0] frz;
    logic [15:0] cnt;
    logic [15:0] c0;
    logic [31:0] rd;
    logic        er;
    logic [31:0] lv;
    logic [31:0] hv;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    dhfc_halt_freeze dut_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .core_halted_i(halt), .timer1_halt_freeze_o(frz[11]),
        .timer3_halt_freeze_o(frz[10]), .timer6_halt_freeze_o(frz[9]),
        .timer7_halt_freeze_o(frz[8]), .timer14_halt_freeze_o(frz[7]),
        .timer15_halt_freeze_o(frz[6]), .timer16_halt_freeze_o(frz[5]),
        .timer17_halt_freeze_o(frz[4]), .calendar_halt_freeze_o(frz[3]),
        .window_watchdog_halt_freeze_o(frz[2]),
        .independent_watchdog_halt_freeze_o(frz[1]),
        .twowire_timeout_halt_freeze_o(frz[0])
    );

    dhfc_counter_model cnt_u
    (
        .clk_i(clk_i), .por_i(por_i), .freeze_i(frz[10]), .count_o(cnt)
    );

    function automatic logic [11:0] exp_frz(input logic [31:0] l,
        input logic [31:0] h, input logic hl);
        exp_frz = hl ? {h[11], l[1], l[4], l[5], l[8], h[16], h[17],
                        h[18], l[10], l[11], l[12], l[21]} : 12'h000;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic cycle; the slave's latency is not assumed, only bounded
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'h1 && err !== 1'h1 && n < 20);
        rd = rdat;
        er = err;
        if (n >= 20)
            n_mismatch++;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask

    task automatic final_report();
        $display("Mismatches %0d of %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always #2 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        void'($urandom(32'hB6F6));
        repeat (3) @(posedge clk_i);
        por_i <= 1'h0;
        rst_i <= 1'h0;
        xfer(1'h0, AL, 4'hF, 32'h0);
        chk("low_rst", rd, `DHFC_FREEZE_RST);
        xfer(1'h0, AH, 4'hF, 32'h0);
        chk("high_rst", rd, `DHFC_FREEZE_RST);
        for (int i = 0; i < 40; i++)
        begin
            lv = (i < 32) ? (32'h1 << i) : $urandom();
            hv = (i < 32) ? (32'h1 << i) : $urandom();
            xfer(1'h1, AL, 4'hF, lv);
            xfer(1'h1, AH, 4'hF, hv);
            xfer(1'h0, AL, 4'hF, 32'h0);
            chk("low_rd", rd, lv & `DHFC_LOW_MASK);
            xfer(1'h0, AH, 4'hF, 32'h0);
            chk("high_rd", rd, hv & `DHFC_HIGH_MASK);
            halt <= 1'h1;
            repeat (7) @(posedge clk_i);
            c0 = cnt;
            chk("frz_on", 32'(frz), 32'(exp_frz(lv, hv, 1'h1)));
            repeat (5) @(posedge clk_i);
            chk("count", 32'(cnt),
                32'(c0 + (lv[1] ? 16'h0 : 16'h5)));
            halt <= 1'h0;
            repeat (7) @(posedge clk_i);
            chk("frz_off", 32'(frz), 32'h0);
        end
        for (int s = 0; s < 16; s++)
        begin
            xfer(1'h1, (s == 15) ? 32'h4001_5800 : AL, 4'(s), 32'hFFFF_FFFF);
            chk("refused", 32'(er), 32'h1);
        end
        xfer(1'h0, AL, 4'hF, 32'h0);
        chk("low_kept", rd, lv & `DHFC_LOW_MASK);
        // Status is read-only; forty halt entries so far, none in reset
        xfer(1'h1, `DHFC_ADDR_STATUS, 4'hF, 32'hFFFF_FFFF);
        chk("status_wr_err", 32'(er), 32'h0);
        xfer(1'h0, `DHFC_ADDR_STATUS, 4'hF, 32'h0);
        chk("status_idle", rd, 32'h0028_0000);
        // Debug host configures while the system sits in reset
        rst_i <= 1'h1;
        halt  <= 1'h1;
        xfer(1'h1, AH, 4'hF, 32'h0);
        xfer(1'h1, AL, 4'hF, 32'h0000_0002);
        xfer(1'h0, AL, 4'hF, 32'h0);
        chk("low_in_rst", rd, 32'h0000_0002);
        repeat (8) @(posedge clk_i);
        chk("frz_rst", 32'(frz), 32'(exp_frz(32'h2, 32'h0, 1'h1)));
        xfer(1'h0, `DHFC_ADDR_STATUS, 4'hF, 32'h0);
        chk("status_rst", rd, 32'h0000_0003);
        rst_i <= 1'h0;
        xfer(1'h0, AL, 4'hF, 32'h0);
        chk("low_after_rst", rd, 32'h0000_0002);
        xfer(1'h0, `DHFC_ADDR_STATUS, 4'hF, 32'h0);
        chk("status_run", rd, 32'h0000_0001);
        por_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        por_i <= 1'h0;
        halt  <= 1'h0;
        xfer(1'h0, AL, 4'hF, 32'h0);
        chk("low_por", rd, `DHFC_FREEZE_RST);
        final_report();
    end
endmodule // tb
